// ===== inc/status_out_pkg.sv
// Constants shared by the drive status-output logic
package status_out_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] OFS_TERMINAL = 6'h00;
  localparam logic [5:0] OFS_RELAY = 6'h04;
  localparam logic [5:0] OFS_ACCEL_THR = 6'h08;
  localparam logic [5:0] OFS_DECEL_THR = 6'h0C;
  localparam logic [5:0] OFS_ZERO_SPEED = 6'h10;
  localparam logic [5:0] OFS_WARN_TIME = 6'h14;
  localparam logic [5:0] OFS_LOGIC_SEL = 6'h18;
  localparam logic [5:0] OFS_MAX_FREQ = 6'h1C;
  localparam logic [5:0] OFS_STATUS = 6'h20;
  localparam logic [5:0] OFS_RUN_HOURS = 6'h24;
  localparam logic [5:0] OFS_ON_HOURS = 6'h28;
  // Logic select field positions
  localparam int LSEL_A_LSB = 0;
  localparam int LSEL_B_LSB = 8;
  localparam int LSEL_OP_LSB = 16;
  // Function codes (decimal codes written in hex)
  localparam logic [7:0] CODE_RUN = 8'h00;
  localparam logic [7:0] CODE_SPEED = 8'h01;
  localparam logic [7:0] CODE_OVER = 8'h02;
  localparam logic [7:0] CODE_ONLY = 8'h06;
  localparam logic [7:0] CODE_RUN_OVR = 8'h0B;
  localparam logic [7:0] CODE_ON_OVR = 8'h0C;
  localparam logic [7:0] CODE_ZERO = 8'h15;
  localparam logic [7:0] CODE_LOG = 8'h21;
  localparam logic [7:0] CODE_MAX = 8'h3C;
  localparam logic [7:0] CODE_NONE = 8'hFF;
  // Logical operators
  localparam logic [1:0] OP_AND = 2'h0;
  localparam logic [1:0] OP_OR = 2'h1;
  localparam logic [1:0] OP_XOR = 2'h2;
  // Flag vector positions
  localparam int FLG_RUN = 0;
  localparam int FLG_SPEED = 1;
  localparam int FLG_OVER = 2;
  localparam int FLG_ONLY = 3;
  localparam int FLG_RUN_OVR = 4;
  localparam int FLG_ON_OVR = 5;
  localparam int FLG_ZERO = 6;
  localparam int FLG_LOG = 7;
  // Frequencies in 0.01 Hz units, then the hysteresis band percentages
  localparam logic [15:0] ARRIVAL_THR_MAX = 16'h9C40;
  localparam logic [15:0] ZERO_SPEED_MAX = 16'h2710;
  localparam logic [15:0] MAX_FREQ_RST = 16'h1770;
  localparam logic [15:0] PCT_ON = 16'h0001;
  localparam logic [15:0] PCT_OFF = 16'h0002;
  localparam logic [15:0] PCT_DIV = 16'h0064;
  // Warning time: units and ranges
  localparam logic [15:0] WARN_MAX = 16'h1999;
  localparam logic [15:0] WARN_EXT_START = 16'h03E8;
  localparam logic [19:0] WARN_UNIT_LO = 20'h0_000A;
  localparam logic [19:0] WARN_UNIT_HI = 20'h0_0064;
  localparam logic [19:0] HOURS_MAX = 20'hF_FFFF;
  // Hour length in control-clock cycles
  localparam longint CLK_HZ = 200_000_000;
  localparam longint HOUR_S = 3600;
  localparam logic [39:0] HOUR_CYCLES_DFLT = 40'(CLK_HZ * HOUR_S);
endpackage : status_out_pkg

// ===== inc/arrival_if.sv
// Carrier between the status top and the frequency-arrival unit
`timescale 1ns/1ps
interface arrival_if;
  logic [15:0] out_freq;
  logic [15:0] cmd_freq;
  logic [15:0] accel_thr;
  logic [15:0] decel_thr;
  logic [15:0] band_on;
  logic [15:0] band_off;
  logic running;
  logic decel;
  logic at_speed;
  logic past_thr;
  logic at_thr;
  modport ctrl (
    output out_freq, cmd_freq, accel_thr, decel_thr, band_on, band_off,
    output running, decel,
    input at_speed, past_thr, at_thr
  );
  modport unit (
    input out_freq, cmd_freq, accel_thr, decel_thr, band_on, band_off,
    input running, decel,
    output at_speed, past_thr, at_thr
  );
endinterface : arrival_if

// ===== hw/arrival_flags.sv
// Frequency-arrival comparators with hysteresis
`timescale 1ns/1ps
module arrival_flags (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the status top
  arrival_if.unit arr
);
  logic signed [17:0] f;
  logic signed [17:0] c;
  logic signed [17:0] t;
  logic signed [17:0] p_on;
  logic signed [17:0] p_off;
  logic t_en;
  logic at_speed_reg;
  logic past_thr_reg;
  logic at_thr_reg;

  assign f = signed'({2'b00, arr.out_freq});
  assign c = signed'({2'b00, arr.cmd_freq});
  assign p_on = signed'({2'b00, arr.band_on});
  assign p_off = signed'({2'b00, arr.band_off});
  // Decelerating uses its own threshold
  assign t = arr.decel ? signed'({2'b00, arr.decel_thr})
                       : signed'({2'b00, arr.accel_thr});
  assign t_en = (t != 18'sd0);

  // Constant-speed arrival against the active command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      at_speed_reg <= 1'b0;
    end else if (!arr.running) begin
      at_speed_reg <= 1'b0;
    end else if (f >= c - p_on) begin
      at_speed_reg <= 1'b1;
    end else if (f < c - p_off) begin
      at_speed_reg <= 1'b0;
    end
  end

  // Overreached: stays on for any frequency past the threshold
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      past_thr_reg <= 1'b0;
    end else if (!t_en || !arr.running) begin
      past_thr_reg <= 1'b0;
    end else if (f >= t - p_on) begin
      past_thr_reg <= 1'b1;
    end else if (f < t - p_off) begin
      past_thr_reg <= 1'b0;
    end
  end

  // Reached-only: drops out on either side of the band
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      at_thr_reg <= 1'b0;
    end else if (!t_en || !arr.running) begin
      at_thr_reg <= 1'b0;
    end else if (f > t + p_off) begin
      at_thr_reg <= 1'b0;
    end else if (f < t - p_off) begin
      at_thr_reg <= 1'b0;
    end else if (!arr.decel && f >= t - p_on) begin
      at_thr_reg <= 1'b1;
    end else if (arr.decel && f <= t + p_on) begin
      at_thr_reg <= 1'b1;
    end
  end

  assign arr.at_speed = at_speed_reg;
  assign arr.past_thr = past_thr_reg;
  assign arr.at_thr = at_thr_reg;
endmodule : arrival_flags

// ===== hw/drive_status_output_logic.sv
// Status-output flag generation and terminal routing of a motor drive
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module drive_status_output_logic
  import status_out_pkg::*;
#(
  parameter logic [39:0] HOUR_CYCLES = HOUR_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Drive state, same clock; frequencies in 0.01 Hz
  input wire logic [15:0] output_freq,
  input wire logic [15:0] active_freq_command,
  input wire logic drive_operating,
  input wire logic dc_braking,
  input wire logic decelerating,
  // Output terminals
  output logic output_terminal,
  output logic alarm_relay
);
  logic [7:0] output_terminal_assignment_reg;
  logic [7:0] relay_assignment_reg;
  logic [15:0] accel_arrival_threshold_reg;
  logic [15:0] decel_arrival_threshold_reg;
  logic [15:0] zero_speed_level_reg;
  logic [15:0] overrun_warning_time_reg;
  logic [7:0] logic_operand_a_select_reg;
  logic [7:0] logic_operand_b_select_reg;
  logic [1:0] logic_operator_select_reg;
  logic [15:0] max_freq_reg;
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic wr_take;
  logic rd_take;
  logic running_flag_reg;
  logic run_time_overrun_flag_reg;
  logic power_on_time_overrun_flag_reg;
  logic zero_speed_flag_reg;
  logic logical_result_flag_reg;
  logic output_terminal_reg;
  logic alarm_relay_reg;
  logic [39:0] run_cycles_reg;
  logic [39:0] on_cycles_reg;
  logic [19:0] run_hours_reg;
  logic [19:0] on_hours_reg;
  logic [19:0] warn_hours;
  logic [15:0] band_on;
  logic [15:0] band_off;
  logic [7:0] flags;
  logic opnd_a;
  logic opnd_b;
  logic logic_next;

  arrival_if arr ();

  // Merge write data into an existing value under the byte enables
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_be

  // Settings beyond their range are held at the top of the range
  function automatic logic [15:0] clamp16(input logic [31:0] v,
                                          input logic [15:0] lim);
    return (v > {16'h0000, lim}) ? lim : v[15:0];
  endfunction : clamp16

  // Flag chosen by a function code; unknown codes read as off
  function automatic logic pick_flag(input logic [7:0] code,
                                     input logic [7:0] fv);
    logic r;
    r = 1'b0;
    case (code)
      CODE_RUN: r = fv[FLG_RUN];
      CODE_SPEED: r = fv[FLG_SPEED];
      CODE_OVER: r = fv[FLG_OVER];
      CODE_ONLY: r = fv[FLG_ONLY];
      CODE_RUN_OVR: r = fv[FLG_RUN_OVR];
      CODE_ON_OVR: r = fv[FLG_ON_OVR];
      CODE_ZERO: r = fv[FLG_ZERO];
      CODE_LOG: r = fv[FLG_LOG];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_flag

  // Operand of the logical flag: itself, none and codes over 60 give off
  function automatic logic pick_operand(input logic [7:0] code,
                                        input logic [7:0] fv);
    logic r;
    r = 1'b0;
    if (code != CODE_LOG && code != CODE_NONE && code <= CODE_MAX) begin
      r = pick_flag(code, fv);
    end
    return r;
  endfunction : pick_operand

  // Bus handshake: one wait cycle, then a single acknowledge cycle
  assign wr_take = write && !waitrequest_reg;
  assign rd_take = read && !waitrequest_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_reg <= 1'b1;
    end else if ((read || write) && waitrequest_reg) begin
      waitrequest_reg <= 1'b0;
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  // Routing and arrival settings
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_terminal_assignment_reg <= CODE_NONE;
      relay_assignment_reg <= CODE_NONE;
      accel_arrival_threshold_reg <= 16'h0000;
      decel_arrival_threshold_reg <= 16'h0000;
      max_freq_reg <= MAX_FREQ_RST;
    end else if (wr_take) begin
      case (address)
        OFS_TERMINAL: output_terminal_assignment_reg <= 8'(merge_be(
          {24'h00_0000, output_terminal_assignment_reg}, writedata,
          byteenable));
        OFS_RELAY: relay_assignment_reg <= 8'(merge_be(
          {24'h00_0000, relay_assignment_reg}, writedata,
          byteenable));
        OFS_ACCEL_THR: accel_arrival_threshold_reg <= clamp16(merge_be(
          {16'h0000, accel_arrival_threshold_reg}, writedata, byteenable),
          ARRIVAL_THR_MAX);
        OFS_DECEL_THR: decel_arrival_threshold_reg <= clamp16(merge_be(
          {16'h0000, decel_arrival_threshold_reg}, writedata, byteenable),
          ARRIVAL_THR_MAX);
        OFS_MAX_FREQ: max_freq_reg <= 16'(merge_be({16'h0000, max_freq_reg},
          writedata, byteenable));
        default: ;
      endcase
    end
  end

  // Detection and logic settings
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_speed_level_reg <= 16'h0000;
      overrun_warning_time_reg <= 16'h0000;
      logic_operand_a_select_reg <= CODE_NONE;
      logic_operand_b_select_reg <= CODE_NONE;
      logic_operator_select_reg <= OP_AND;
    end else if (wr_take) begin
      case (address)
        OFS_ZERO_SPEED: zero_speed_level_reg <= clamp16(merge_be(
          {16'h0000, zero_speed_level_reg}, writedata, byteenable),
          ZERO_SPEED_MAX);
        OFS_WARN_TIME: overrun_warning_time_reg <= clamp16(merge_be(
          {16'h0000, overrun_warning_time_reg}, writedata, byteenable),
          WARN_MAX);
        OFS_LOGIC_SEL: begin
          if (byteenable[0]) begin
            logic_operand_a_select_reg <= writedata[LSEL_A_LSB +: 8];
          end
          if (byteenable[1]) begin
            logic_operand_b_select_reg <= writedata[LSEL_B_LSB +: 8];
          end
          if (byteenable[2]) begin
            logic_operator_select_reg <= writedata[LSEL_OP_LSB +: 2];
          end
        end
        default: ;
      endcase
    end
  end

  // Read data, unmapped offsets read zero
  always_comb begin
    readdata_next = 32'h0000_0000;
    case (address)
      OFS_TERMINAL: readdata_next = {24'h00_0000,
                                     output_terminal_assignment_reg};
      OFS_RELAY: readdata_next = {24'h00_0000, relay_assignment_reg};
      OFS_ACCEL_THR: readdata_next = {16'h0000,
                                      accel_arrival_threshold_reg};
      OFS_DECEL_THR: readdata_next = {16'h0000,
                                      decel_arrival_threshold_reg};
      OFS_ZERO_SPEED: readdata_next = {16'h0000, zero_speed_level_reg};
      OFS_WARN_TIME: readdata_next = {16'h0000, overrun_warning_time_reg};
      OFS_LOGIC_SEL: readdata_next = {14'h0000, logic_operator_select_reg,
                                      logic_operand_b_select_reg,
                                      logic_operand_a_select_reg};
      OFS_MAX_FREQ: readdata_next = {16'h0000, max_freq_reg};
      OFS_STATUS: readdata_next = {24'h00_0000, flags};
      OFS_RUN_HOURS: readdata_next = {12'h000, run_hours_reg};
      OFS_ON_HOURS: readdata_next = {12'h000, on_hours_reg};
      default: readdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read && waitrequest_reg) begin
      readdata_reg <= readdata_next;
    end
  end

  // Running flag: braking counts as operating
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      running_flag_reg <= 1'b0;
    end else begin
      running_flag_reg <= drive_operating || dc_braking;
    end
  end

  // Hysteresis bands as 1% and 2% of the maximum frequency
  assign band_on = 16'((32'(max_freq_reg) * 32'(PCT_ON)) / 32'(PCT_DIV));
  assign band_off = 16'((32'(max_freq_reg) * 32'(PCT_OFF)) / 32'(PCT_DIV));

  assign arr.out_freq = output_freq;
  assign arr.cmd_freq = active_freq_command;
  assign arr.accel_thr = accel_arrival_threshold_reg;
  assign arr.decel_thr = decel_arrival_threshold_reg;
  assign arr.band_on = band_on;
  assign arr.band_off = band_off;
  assign arr.running = drive_operating || dc_braking;
  assign arr.decel = decelerating;

  arrival_flags u_arrival (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .arr (arr.unit)
  );

  // Elapsed time; hour counters saturate rather than wrap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      on_cycles_reg <= 40'h00_0000_0000;
      on_hours_reg <= 20'h0_0000;
    end else if (on_cycles_reg >= HOUR_CYCLES - 40'h00_0000_0001) begin
      on_cycles_reg <= 40'h00_0000_0000;
      if (on_hours_reg != HOURS_MAX) begin
        on_hours_reg <= on_hours_reg + 20'h0_0001;
      end
    end else begin
      on_cycles_reg <= on_cycles_reg + 40'h00_0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_cycles_reg <= 40'h00_0000_0000;
      run_hours_reg <= 20'h0_0000;
    end else if (drive_operating || dc_braking) begin
      if (run_cycles_reg >= HOUR_CYCLES - 40'h00_0000_0001) begin
        run_cycles_reg <= 40'h00_0000_0000;
        if (run_hours_reg != HOURS_MAX) begin
          run_hours_reg <= run_hours_reg + 20'h0_0001;
        end
      end else begin
        run_cycles_reg <= run_cycles_reg + 40'h00_0000_0001;
      end
    end
  end

  // Warning time in hours: low range in tens, extended in hundreds
  assign warn_hours = (overrun_warning_time_reg < WARN_EXT_START)
    ? 20'(20'(overrun_warning_time_reg) * WARN_UNIT_LO)
    : 20'(20'(overrun_warning_time_reg) * WARN_UNIT_HI);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_time_overrun_flag_reg <= 1'b0;
      power_on_time_overrun_flag_reg <= 1'b0;
    end else begin
      run_time_overrun_flag_reg <= (overrun_warning_time_reg != 16'h0000)
        && (run_hours_reg > warn_hours);
      power_on_time_overrun_flag_reg <=
        (overrun_warning_time_reg != 16'h0000)
        && (on_hours_reg > warn_hours);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_speed_flag_reg <= 1'b0;
    end else begin
      zero_speed_flag_reg <= output_freq < zero_speed_level_reg;
    end
  end

  // All flags, each from a flip-flop
  assign flags[FLG_RUN] = running_flag_reg;
  assign flags[FLG_SPEED] = arr.at_speed;
  assign flags[FLG_OVER] = arr.past_thr;
  assign flags[FLG_ONLY] = arr.at_thr;
  assign flags[FLG_RUN_OVR] = run_time_overrun_flag_reg;
  assign flags[FLG_ON_OVR] = power_on_time_overrun_flag_reg;
  assign flags[FLG_ZERO] = zero_speed_flag_reg;
  assign flags[FLG_LOG] = logical_result_flag_reg;

  // Logical result; reading its own flag is blocked to avoid a loop
  assign opnd_a = pick_operand(logic_operand_a_select_reg, flags);
  assign opnd_b = pick_operand(logic_operand_b_select_reg, flags);

  always_comb begin
    logic_next = 1'b0;
    case (logic_operator_select_reg)
      OP_AND: logic_next = opnd_a & opnd_b;
      OP_OR: logic_next = opnd_a | opnd_b;
      OP_XOR: logic_next = opnd_a ^ opnd_b;
      default: logic_next = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      logical_result_flag_reg <= 1'b0;
    end else begin
      logical_result_flag_reg <= logic_next;
    end
  end

  // Terminal routing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_terminal_reg <= 1'b0;
      alarm_relay_reg <= 1'b0;
    end else begin
      output_terminal_reg <=
        pick_flag(output_terminal_assignment_reg, flags);
      alarm_relay_reg <= pick_flag(relay_assignment_reg, flags);
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign output_terminal = output_terminal_reg;
  assign alarm_relay = alarm_relay_reg;
endmodule : drive_status_output_logic

// ===== bench/drive_status_output_logic_checker.sv
// Port assertions for the drive status-output logic
`timescale 1ns/1ps
module drive_status_output_logic_checker
  import status_out_pkg::*;
#(
  parameter logic [39:0] HOUR_CYCLES = HOUR_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Drive state and terminals
  input wire logic drive_operating,
  input wire logic dc_braking,
  input wire logic output_terminal,
  input wire logic alarm_relay
);
  // Shadows follow full-word writes only; partial writes would mislead them
  logic [7:0] term_reg;
  logic [7:0] relay_reg;
  logic wr_ok;
  logic run_now;
  assign wr_ok = write && !waitrequest && byteenable == 4'hF;
  assign run_now = drive_operating || dc_braking;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      term_reg <= CODE_NONE;
      relay_reg <= CODE_NONE;
    end else if (wr_ok && address == OFS_TERMINAL) begin
      term_reg <= writedata[7:0];
    end else if (wr_ok && address == OFS_RELAY) begin
      relay_reg <= writedata[7:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_next:
    assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in the next cycle");
  chk_ack_single:
    assert property (!waitrequest |=> waitrequest)
    else $error("acknowledge longer than one cycle");
  chk_idle_wait:
    assert property (!read && !write |-> waitrequest)
    else $error("acknowledge without request");
  chk_unmapped_zero:
    assert property (read && !waitrequest && address > OFS_ON_HOURS
      |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_run_term:
    assert property ((term_reg == CODE_RUN) [*3]
      |-> output_terminal == $past(run_now, 2))
    else $error("terminal does not follow running state");
  chk_run_relay:
    assert property ((relay_reg == CODE_RUN) [*3]
      |-> alarm_relay == $past(run_now, 2))
    else $error("relay does not follow running state");
  chk_term_unknown:
    assert property ((term_reg > CODE_LOG) [*2] |-> !output_terminal)
    else $error("terminal high for unknown code");
  chk_relay_unknown:
    assert property ((relay_reg > CODE_LOG) [*2] |-> !alarm_relay)
    else $error("relay high for unknown code");
endmodule : drive_status_output_logic_checker

bind drive_status_output_logic drive_status_output_logic_checker #(
  .HOUR_CYCLES(HOUR_CYCLES)
) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest),
  .drive_operating(drive_operating), .dc_braking(dc_braking),
  .output_terminal(output_terminal), .alarm_relay(alarm_relay)
);

// ===== bench/terminal_sampler.sv
// External controller model that samples the drive's output terminals
`timescale 1ns/1ps
module terminal_sampler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Terminals and sampled levels
  input wire logic output_terminal,
  input wire logic alarm_relay,
  output logic term_seen,
  output logic relay_seen
);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      term_seen <= 1'b0;
      relay_seen <= 1'b0;
    end else begin
      term_seen <= output_terminal;
      relay_seen <= alarm_relay;
    end
  end
endmodule : terminal_sampler

// ===== bench/test_drive_status_output_logic.sv
// Self-checking testbench of the drive status-output logic
`timescale 1ns/1ps
module test_drive_status_output_logic
  import status_out_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [15:0] output_freq = 16'h0000;
  logic [15:0] active_freq_command = 16'h0BB8;
  logic drive_operating = 1'b0;
  logic dc_braking = 1'b0;
  logic decelerating = 1'b0;
  logic output_terminal;
  logic alarm_relay;
  logic term_seen;
  logic relay_seen;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  // Ten cycles per hour keeps the overrun counters reachable
  drive_status_output_logic #(.HOUR_CYCLES(40'h00_0000_000A)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .output_freq(output_freq), .active_freq_command(active_freq_command),
    .drive_operating(drive_operating), .dc_braking(dc_braking),
    .decelerating(decelerating), .output_terminal(output_terminal),
    .alarm_relay(alarm_relay)
  );
  terminal_sampler ctl (
    .sys_clk(sys_clk), .rst_n(rst_n), .output_terminal(output_terminal),
    .alarm_relay(alarm_relay), .term_seen(term_seen),
    .relay_seen(relay_seen)
  );
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk_val(input string what, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk_val
  task automatic chk_pin(input string what, input logic e, g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask : chk_pin
  // Holds the request until waitrequest is seen low, then lets an edge pass
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input string what, input logic [5:0] a,
                    input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    chk_val(what, e, x);
  endtask : rd
  // State bits: operating, braking, decelerating
  task automatic step(input logic [15:0] f, input logic [2:0] st,
                      input logic et, input logic er);
    output_freq <= f;
    {drive_operating, dc_braking, decelerating} <= st;
    repeat (6) @(posedge sys_clk);
    chk_pin("terminal", et, term_seen);
    chk_pin("relay", er, relay_seen);
  endtask : step
  task automatic t_regs();
    rd("terminal code", OFS_TERMINAL, 32'h0000_00FF);
    rd("logic select", OFS_LOGIC_SEL, 32'h0000_FFFF);
    rd("max freq", OFS_MAX_FREQ, 32'h0000_1770);
    wr(OFS_ACCEL_THR, 32'h0000_FFFF);
    rd("accel thr", OFS_ACCEL_THR, 32'(ARRIVAL_THR_MAX));
    wr(OFS_ZERO_SPEED, 32'h0000_FFFF);
    rd("zero level", OFS_ZERO_SPEED, 32'(ZERO_SPEED_MAX));
    wr(6'h2C, 32'h1234_5678);
    rd("unmapped", 6'h2C, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_fa();
    wr(OFS_ACCEL_THR, 32'h0000_07D0);
    wr(OFS_TERMINAL, 32'(CODE_SPEED));
    wr(OFS_RELAY, 32'(CODE_OVER));
    step(16'h0794, 3'b100, 1'b0, 1'b1);
    step(16'h0759, 3'b100, 1'b0, 1'b1);
    step(16'h0757, 3'b100, 1'b0, 1'b0);
    step(16'h0B7B, 3'b100, 1'b0, 1'b1);
    step(16'h0B7C, 3'b100, 1'b1, 1'b1);
    step(16'h0B3F, 3'b100, 1'b0, 1'b1);
    active_freq_command <= 16'h0B54;
    step(16'h0B3F, 3'b100, 1'b1, 1'b1);
    wr(OFS_ACCEL_THR, 32'h0000_0000);
    step(16'h0B3F, 3'b100, 1'b1, 1'b0);
    $display("test arrival done");
  endtask : t_fa
  task automatic t_reached();
    wr(OFS_ACCEL_THR, 32'h0000_07D0);
    wr(OFS_DECEL_THR, 32'h0000_0BB8);
    wr(OFS_TERMINAL, 32'(CODE_ONLY));
    wr(OFS_RELAY, 32'(CODE_MAX));
    step(16'h0794, 3'b100, 1'b1, 1'b0);
    step(16'h0848, 3'b100, 1'b1, 1'b0);
    step(16'h0849, 3'b100, 1'b0, 1'b0);
    step(16'h0BF5, 3'b101, 1'b0, 1'b0);
    step(16'h0BF4, 3'b101, 1'b1, 1'b0);
    step(16'h0B3F, 3'b101, 1'b0, 1'b0);
    wr(OFS_DECEL_THR, 32'h0000_0000);
    step(16'h0BF4, 3'b101, 1'b0, 1'b0);
    $display("test reached only done");
  endtask : t_reached
  task automatic t_zero_run();
    wr(OFS_ZERO_SPEED, 32'h0000_01F4);
    wr(OFS_TERMINAL, 32'(CODE_RUN));
    wr(OFS_RELAY, 32'(CODE_ZERO));
    step(16'h01F3, 3'b100, 1'b1, 1'b1);
    step(16'h01F4, 3'b010, 1'b1, 1'b0);
    step(16'h0000, 3'b000, 1'b0, 1'b1);
    $display("test zero speed done");
  endtask : t_zero_run
  task automatic t_ovr();
    wr(OFS_WARN_TIME, 32'h0000_0000);
    wr(OFS_TERMINAL, 32'(CODE_RUN_OVR));
    wr(OFS_RELAY, 32'(CODE_ON_OVR));
    step(16'h0064, 3'b100, 1'b0, 1'b0);
    repeat (150) @(posedge sys_clk);
    wr(OFS_WARN_TIME, 32'h0000_03E8);
    step(16'h0064, 3'b000, 1'b0, 1'b0);
    wr(OFS_WARN_TIME, 32'h0000_0001);
    step(16'h0064, 3'b000, 1'b1, 1'b1);
    $display("test overrun done");
  endtask : t_ovr
  task automatic t_log();
    wr(OFS_ACCEL_THR, 32'h0000_07D0);
    wr(OFS_TERMINAL, 32'(CODE_LOG));
    wr(OFS_RELAY, 32'(CODE_OVER));
    for (int i = 0; i < 4; i++) begin
      wr(OFS_LOGIC_SEL, {14'h0000, 2'(i), CODE_OVER, CODE_RUN});
      step(16'h0064, 3'b100, i == 1 || i == 2, 1'b0);
    end
    wr(OFS_LOGIC_SEL, {14'h0000, OP_AND, CODE_OVER, CODE_RUN});
    step(16'h0794, 3'b100, 1'b1, 1'b1);
    wr(OFS_LOGIC_SEL, {14'h0000, OP_OR, CODE_NONE, CODE_LOG});
    step(16'h0794, 3'b100, 1'b0, 1'b1);
    wr(OFS_LOGIC_SEL, {14'h0000, OP_OR, CODE_NONE, 8'h3D});
    step(16'h0794, 3'b100, 1'b0, 1'b1);
    rd("status", OFS_STATUS, 32'h0000_003D);
    $display("test logic done");
  endtask : t_log
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_fa();
    t_reached();
    t_zero_run();
    t_ovr();
    t_log();
    finish_test();
  end
endmodule : test_drive_status_output_logic
